/* File: common/uepc_cfg.svh */
// Register offsets, field positions and reset values for the IN endpoint control block
`ifndef UEPC_CFG_SVH
`define UEPC_CFG_SVH
`define UEPC_ADDR_SUMMARY 4'h0
`define UEPC_ADDR_IRQ_MASK 4'h1
`define UEPC_ADDR_EMPTY_MASK 4'h2
`define UEPC_ADDR_EP0_CTRL 4'h3
`define UEPC_ADDR_EPX_BASE 4'h4
`define UEPC_ADDR_STATUS 4'h7
`define UEPC_OUT_LSB 16
`define UEPC_IN_LSB 0
`define UEPC_BIT_ENABLE 31
`define UEPC_BIT_DISABLE 30
`define UEPC_BIT_DATA1 29
`define UEPC_BIT_DATA0 28
`define UEPC_BIT_SET_NAK 27
`define UEPC_BIT_CLR_NAK 26
`define UEPC_FIFO_LSB 22
`define UEPC_BIT_STALL 21
`define UEPC_TYPE_LSB 18
`define UEPC_BIT_NAK 17
`define UEPC_BIT_PID 16
`define UEPC_BIT_ACTIVE 15
`define UEPC_MPS_LSB 0
`define UEPC_RESET_WORD 32'h0000_0000
`endif

/* File: common/uepc_pkg.sv */
// Types shared by the IN endpoint control block
package uepc_pkg;
  typedef enum logic [1:0] {
    UEPC_XFER_CONTROL,
    UEPC_XFER_ISOCH,
    UEPC_XFER_BULK,
    UEPC_XFER_INTERRUPT
  } uepc_xfer_e;
  typedef enum logic [1:0] {
    UEPC_HS_DATA,
    UEPC_HS_NAK,
    UEPC_HS_STALL,
    UEPC_HS_ZLP
  } uepc_hs_e;
  typedef logic [31:0] uepc_word_t;
endpackage

/* File: design/uepc_in_endpoint_ctrl.sv */
// IN endpoint control registers and endpoint interrupt summary for the device controller
//
// Overview of operation
// [RULE1] One summary bit per endpoint: OUT in 23..16, IN in 7..0.
// [RULE2] Summary bits follow each endpoint's own flags and are read-only.
// [RULE3] A bidirectional endpoint uses its IN and OUT summary bits together.
// [RULE4] Mask register gates interrupt; masked events still set their summary bit.
// [RULE5] Eight-bit mask gates each IN endpoint's FIFO-empty interrupt.
// [RULE6] Enable bit cleared by device before disabled, complete or setup-done events; setup-done does not clear endpoint 0's enable.
// [RULE7] Disable bit stops transmission; cleared before the disabled event is raised.
// [RULE8] Software disables only enabled endpoints and waits for the disabled event.
// [RULE9] Set-NAK write sets NAK; endpoint 0 also sets NAK on SETUP data.
// [RULE10] Nonzero endpoints set NAK on transfer complete or SETUP received.
// [RULE11] Clear-NAK write of one clears NAK; zero has no effect.
// [RULE12] Four-bit FIFO select; endpoint 0 only FIFO 0; one FIFO each.
// [RULE13] Endpoint 0 STALL cleared by SETUP token; STALL beats all NAKs.
// [RULE14] Nonzero endpoint STALL stalls all tokens; only software clears it. An isochronous endpoint is never stalled.
// [RULE15] Endpoint 0 transfer type is read-only zero, meaning control.
// [RULE16] Nonzero transfer type writable: control, isochronous, bulk, interrupt.
// [RULE17] NAK state answers NAK; isochronous IN sends zero-length packet instead.
// [RULE18] SETUP data packets are always acknowledged, whatever the NAK state.
// [RULE19] Endpoint 0 active bit always reads one.
// [RULE20] Endpoint 0 packet size code: 64, 32, 16 or 8 bytes.
// [RULE21] Bit 29 write forces DATA1 or odd frame; endpoint 0 ignores it.
// [RULE22] Bit 28 write forces DATA0 or even frame; endpoint 0 ignores it.
// [RULE23] Read-only PID bit: zero DATA0 or even, one DATA1 or odd; endpoint 0 always reads zero.
// [RULE24] Bus reset clears active bit of every endpoint but endpoint 0.
// [RULE25] Nonzero endpoints hold an eleven-bit packet size in bytes.
// [RULE26] Interrupt request is high while any unmasked summary bit is set.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "uepc_cfg.svh"
module uepc_in_endpoint_ctrl #(
  parameter int NUM_IN = 4,
  parameter int NUM_EP = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [NUM_EP-1:0] in_ep_flags_any,
  input wire logic [NUM_EP-1:0] out_ep_flags_any,
  input wire logic [NUM_IN-1:0] tx_fifo_empty_flag,
  input wire logic [NUM_IN-1:0] xfer_done_evt,
  input wire logic [NUM_IN-1:0] setup_done_evt,
  input wire logic [NUM_IN-1:0] setup_rx_evt,
  input wire logic [NUM_IN-1:0] pid_toggle_evt,
  input wire logic [NUM_IN-1:0] disable_done_evt,
  input wire logic usb_reset_evt,
  input wire logic global_in_nak,
  input wire logic global_out_nak,
  output logic [NUM_IN-1:0] endpoint_enable_bit,
  output logic [NUM_IN-1:0] disabled_irq_pulse,
  output uepc_pkg::uepc_hs_e in_handshake [NUM_IN],
  output logic [NUM_IN-1:0] tx_halt,
  output logic [NUM_IN-1:0] fifo_empty_irq,
  output logic ep_irq
);
  import uepc_pkg::*;

  // Per-endpoint control state, index 0 is endpoint 0
  logic [NUM_IN-1:0] enable_reg;
  logic [NUM_IN-1:0] disable_reg;
  logic [NUM_IN-1:0] nak_reg;
  logic [NUM_IN-1:0] stall_reg;
  logic [NUM_IN-1:0] pid_reg;
  logic [NUM_IN-1:0] active_reg;
  logic [NUM_IN-1:0] disabled_pulse_reg;
  logic [NUM_IN-1:0] dis_seen_reg;
  logic [3:0] fifo_reg [NUM_IN];
  logic [1:0] type_reg [NUM_IN];
  logic [10:0] mps_reg [NUM_IN];
  logic [31:0] irq_mask_reg;
  logic [7:0] empty_mask_reg;
  logic [31:0] summary;
  logic [31:0] readdata_reg;
  logic ack_reg;
  logic [1:0] resp_reg;
  logic req;
  logic wr_hit;

  // Endpoint control register index for an address, NUM_IN when none
  // Addresses past the last endpoint fall through as unmapped
  function automatic int ctrl_index(input logic [3:0] addr);
    int idx;
    idx = NUM_IN;
    if (addr == `UEPC_ADDR_EP0_CTRL) begin
      idx = 0;
    end else if (addr >= `UEPC_ADDR_EPX_BASE &&
                 int'(addr) < int'(`UEPC_ADDR_EPX_BASE) + NUM_IN - 1) begin
      idx = int'(addr) - int'(`UEPC_ADDR_EPX_BASE) + 1;
    end
    return idx;
  endfunction

  // Known address test, also used to pick the bus response
  function automatic logic addr_known(input logic [3:0] addr);
    return (addr <= `UEPC_ADDR_EP0_CTRL) || (ctrl_index(addr) != NUM_IN) ||
           (addr == `UEPC_ADDR_STATUS);
  endfunction

  // One wait cycle per access; the answer comes at the second edge
  // Writes land and read data is captured at the first edge, so the data
  // already stands when the master sees the wait lifted
  assign req = (avs_read || avs_write) && !ack_reg;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_hit = avs_write && !ack_reg && (avs_byteenable == 4'hf);
  assign avs_readdata = readdata_reg;
  assign avs_response = resp_reg;

  // Bus acknowledge, one cycle after the request is seen
  // A request held past the lifted wait is taken again: ack lifts the wait for one cycle only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Response code, valid in the cycle the wait is lifted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      resp_reg <= 2'h0;
    end else if (req && !addr_known(avs_address)) begin
      resp_reg <= 2'h2;
    end else begin
      resp_reg <= 2'h0;
    end
  end

  // [RULE1] summary bit layout
  // [RULE2] follows endpoint flags
  // [RULE3] both directions kept separately
  always_comb begin
    // Reserved bytes 31..24 and 15..8 stay zero
    summary = `UEPC_RESET_WORD;
    summary[`UEPC_OUT_LSB +: 8] = 8'(out_ep_flags_any);
    summary[`UEPC_IN_LSB +: 8] = 8'(in_ep_flags_any);
  end

  // [RULE26] unmasked summary raises request
  // [RULE4] mask gates only the output
  assign ep_irq = |(summary & irq_mask_reg);

  // Endpoint interrupt mask
  // Reserved bits are dropped on write so they always read zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_reg <= `UEPC_RESET_WORD;
    end else if (wr_hit && avs_address == `UEPC_ADDR_IRQ_MASK) begin
      irq_mask_reg <= avs_writedata & 32'h00ff_00ff;
    end
  end

  // [RULE5] FIFO-empty mask write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      empty_mask_reg <= 8'h00;
    end else if (wr_hit && avs_address == `UEPC_ADDR_EMPTY_MASK) begin
      empty_mask_reg <= avs_writedata[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_ep
      // Write strobe for this endpoint's control word
      logic wr_me;
      assign wr_me = wr_hit && (ctrl_index(avs_address) == g);

      // [RULE5] FIFO-empty interrupt gating
      assign fifo_empty_irq[g] = tx_fifo_empty_flag[g] & empty_mask_reg[g];

      // Enable and disable; events from the engine clear them before the pulse
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          enable_reg[g] <= 1'b0;
          disable_reg[g] <= 1'b0;
          dis_seen_reg[g] <= 1'b0;
          disabled_pulse_reg[g] <= 1'b0;
        end else begin
          // Event waits a cycle so both bits already read zero when it rises
          dis_seen_reg[g] <= 1'b0;
          disabled_pulse_reg[g] <= dis_seen_reg[g];
          // [RULE7] disable stops endpoint
          if (disable_reg[g] && (disable_done_evt[g] || !enable_reg[g])) begin
            disable_reg[g] <= 1'b0;
            enable_reg[g] <= 1'b0;
            dis_seen_reg[g] <= 1'b1;
          // [RULE6] clear enable on events
          end else if (xfer_done_evt[g] || (g != 0 && setup_done_evt[g])) begin
            enable_reg[g] <= 1'b0;
          end else if (wr_me) begin
            if (avs_writedata[`UEPC_BIT_ENABLE]) begin
              enable_reg[g] <= 1'b1;
            end
            // [RULE8] only honoured while enabled
            if (avs_writedata[`UEPC_BIT_DISABLE] && enable_reg[g]) begin
              disable_reg[g] <= 1'b1;
            end
          end
        end
      end

      // NAK state: hardware set wins over a clear in the same cycle
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          nak_reg[g] <= 1'b0;
        end else if (setup_rx_evt[g] || (g != 0 && xfer_done_evt[g])) begin
          // [RULE9] SETUP sets NAK
          // [RULE10] auto NAK nonzero
          nak_reg[g] <= 1'b1;
        end else if (wr_me && avs_writedata[`UEPC_BIT_SET_NAK]) begin
          // [RULE9] software set NAK
          nak_reg[g] <= 1'b1;
        end else if (wr_me && avs_writedata[`UEPC_BIT_CLR_NAK]) begin
          // [RULE11] clear NAK on one
          nak_reg[g] <= 1'b0;
        end
      end

      // STALL handling differs for endpoint 0
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          stall_reg[g] <= 1'b0;
        end else if (g == 0) begin
          // [RULE13] SETUP clears stall
          if (setup_rx_evt[g]) begin
            stall_reg[g] <= 1'b0;
          end else if (wr_me && avs_writedata[`UEPC_BIT_STALL]) begin
            stall_reg[g] <= 1'b1;
          end
        end else if (wr_me) begin
          // [RULE14] software only
          stall_reg[g] <= avs_writedata[`UEPC_BIT_STALL];
        end
      end

      // Transmit FIFO number; software must give each endpoint its own FIFO
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          fifo_reg[g] <= 4'h0;
        end else if (wr_me) begin
          // [RULE12] endpoint 0 pinned to FIFO 0
          fifo_reg[g] <= (g == 0) ? 4'h0 : avs_writedata[`UEPC_FIFO_LSB +: 4];
        end
      end

      // Transfer type
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          type_reg[g] <= 2'h0;
        end else if (wr_me) begin
          // [RULE15] endpoint 0 type fixed
          // [RULE16] writable type
          type_reg[g] <= (g == 0) ? 2'h0 : avs_writedata[`UEPC_TYPE_LSB +: 2];
        end
      end

      // Packet size: a two-bit code on endpoint 0, a byte count elsewhere
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          mps_reg[g] <= 11'h000;
        end else if (wr_me) begin
          // [RULE20] ep0 size code
          // [RULE25] eleven-bit size
          mps_reg[g] <= (g == 0) ? {9'h000, avs_writedata[1:0]}
                                 : avs_writedata[`UEPC_MPS_LSB +: 11];
        end
      end

      // Active bit; endpoint 0 can never be deactivated
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          active_reg[g] <= (g == 0);
        end else begin
          // [RULE19] ep0 always active
          // [RULE24] bus reset clears others
          if (g == 0) begin
            active_reg[g] <= 1'b1;
          end else if (usb_reset_evt) begin
            active_reg[g] <= 1'b0;
          end else if (wr_me) begin
            active_reg[g] <= avs_writedata[`UEPC_BIT_ACTIVE];
          end
        end
      end

      // Data PID or frame parity; a software force beats an engine toggle
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pid_reg[g] <= 1'b0;
        end else begin
          // [RULE21] force DATA1 or odd
          // [RULE22] force DATA0 or even
          if (g != 0 && wr_me && avs_writedata[`UEPC_BIT_DATA1]) begin
            pid_reg[g] <= 1'b1;
          end else if (g != 0 && wr_me && avs_writedata[`UEPC_BIT_DATA0]) begin
            pid_reg[g] <= 1'b0;
          end else if (pid_toggle_evt[g]) begin
            pid_reg[g] <= ~pid_reg[g];
          end
        end
      end

      // Isochronous traffic is never stalled and is not held off by the global NAK
      logic is_iso;
      logic stall_on;
      logic nak_on;
      assign is_iso = (type_reg[g] == 2'(UEPC_XFER_ISOCH));
      assign stall_on = stall_reg[g] && !is_iso;
      assign nak_on = nak_reg[g] || (global_in_nak && !is_iso);

      // Handshake choice; SETUP data is acknowledged by the engine regardless of NAK
      always_comb begin
        // [RULE13] stall beats every NAK
        // [RULE14] stall all tokens
        // [RULE17] NAK or zero-length
        // [RULE18] SETUP bypasses this
        if (stall_on) begin
          in_handshake[g] = UEPC_HS_STALL;
        end else if (nak_reg[g] && is_iso) begin
          in_handshake[g] = UEPC_HS_ZLP;
        end else if (nak_on) begin
          in_handshake[g] = UEPC_HS_NAK;
        end else begin
          in_handshake[g] = UEPC_HS_DATA;
        end
      end
      // Halt also covers NAK, STALL and zero-length answers
      // [RULE7] halt on disable
      assign tx_halt[g] = !enable_reg[g] || disable_reg[g] || (in_handshake[g] != UEPC_HS_DATA);
    end
  endgenerate

  assign endpoint_enable_bit = enable_reg;
  assign disabled_irq_pulse = disabled_pulse_reg;

  // Read data, captured while the request waits
  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= `UEPC_RESET_WORD;
    end else if (req && avs_read) begin
      readdata_reg <= `UEPC_RESET_WORD;
      if (avs_address == `UEPC_ADDR_SUMMARY) begin
        readdata_reg <= summary;
      end else if (avs_address == `UEPC_ADDR_IRQ_MASK) begin
        readdata_reg <= irq_mask_reg;
      end else if (avs_address == `UEPC_ADDR_EMPTY_MASK) begin
        readdata_reg <= {24'h00_0000, empty_mask_reg};
      end else if (avs_address == `UEPC_ADDR_STATUS) begin
        readdata_reg <= {30'h0000_0000, global_out_nak, global_in_nak};
      end else begin
        for (int i = 0; i < NUM_IN; i++) begin
          if (ctrl_index(avs_address) == i) begin
            readdata_reg[`UEPC_BIT_ENABLE] <= enable_reg[i];
            readdata_reg[`UEPC_BIT_DISABLE] <= disable_reg[i];
            readdata_reg[`UEPC_FIFO_LSB +: 4] <= fifo_reg[i];
            readdata_reg[`UEPC_BIT_STALL] <= stall_reg[i];
            readdata_reg[`UEPC_TYPE_LSB +: 2] <= type_reg[i];
            readdata_reg[`UEPC_BIT_NAK] <= nak_reg[i];
            // [RULE23] PID or frame bit
            readdata_reg[`UEPC_BIT_PID] <= (i != 0) && pid_reg[i];
            readdata_reg[`UEPC_BIT_ACTIVE] <= active_reg[i];
            readdata_reg[`UEPC_MPS_LSB +: 11] <= mps_reg[i];
          end
        end
      end
    end
  end
endmodule // uepc_in_endpoint_ctrl

/* File: testbench/uepc_in_endpoint_ctrl_monitor.sv */
// Port checker for the IN endpoint control block
`timescale 1ns/1ps
module uepc_in_endpoint_ctrl_monitor #(
  parameter int NUM_IN = 4,
  parameter int NUM_EP = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [NUM_EP-1:0] in_ep_flags_any,
  input wire logic [NUM_EP-1:0] out_ep_flags_any,
  input wire logic [NUM_IN-1:0] tx_fifo_empty_flag,
  input wire logic [NUM_IN-1:0] xfer_done_evt,
  input wire logic [NUM_IN-1:0] setup_done_evt,
  input wire logic [NUM_IN-1:0] endpoint_enable_bit,
  input wire logic [NUM_IN-1:0] disabled_irq_pulse,
  input wire logic [NUM_IN-1:0] fifo_empty_irq,
  input wire logic ep_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Two quiet cycles, though the summary is combinational with no registered stage
  property p_irq_quiet;
    (in_ep_flags_any == '0 && out_ep_flags_any == '0) [*2] |-> !ep_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("endpoint irq without flags");
  property p_fifo_gate;
    (fifo_empty_irq & ~tx_fifo_empty_flag) == '0;
  endproperty
  a_fifo_gate: assert property (p_fifo_gate) else $error("fifo empty irq without flag");
  property p_xfer_clear;
    (|xfer_done_evt) |=> (endpoint_enable_bit & $past(xfer_done_evt)) == '0;
  endproperty
  a_xfer_clear: assert property (p_xfer_clear) else $error("enable kept after completion");
  property p_setup_clear;
    (|setup_done_evt[NUM_IN-1:1]) |=>
      (endpoint_enable_bit[NUM_IN-1:1] & $past(setup_done_evt[NUM_IN-1:1])) == '0;
  endproperty
  a_setup_clear: assert property (p_setup_clear) else $error("enable kept after setup");
  // Disabled event only once the enable has already dropped
  property p_dis_after;
    (|disabled_irq_pulse) |-> (disabled_irq_pulse & $past(endpoint_enable_bit)) == '0;
  endproperty
  a_dis_after: assert property (p_dis_after) else $error("disabled event too early");
  property p_dis_single;
    (|disabled_irq_pulse) |=> (disabled_irq_pulse & $past(disabled_irq_pulse)) == '0;
  endproperty
  a_dis_single: assert property (p_dis_single) else $error("disabled event too long");
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle"); // bus
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle"); // bus
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait while idle"); // bus
endmodule // uepc_in_endpoint_ctrl_monitor
bind uepc_in_endpoint_ctrl uepc_in_endpoint_ctrl_monitor #(.NUM_IN(NUM_IN), .NUM_EP(NUM_EP))
  uepc_in_endpoint_ctrl_monitor_i (.ref_clk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .in_ep_flags_any, .out_ep_flags_any, .tx_fifo_empty_flag,
  .xfer_done_evt, .setup_done_evt, .endpoint_enable_bit, .disabled_irq_pulse,
  .fifo_empty_irq, .ep_irq);

/* File: testbench/uepc_host_model.sv */
// Bus-side traffic model: packet engine events seen from the host's tokens
`timescale 1ns/1ps
module uepc_host_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [1:0] ep,
  output logic [3:0] xfer_done,
  output logic [3:0] setup_done,
  output logic [3:0] setup_rx,
  output logic [3:0] dis_done,
  output logic usb_rst
);
  // One-cycle pulses only, so no event can be counted twice
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {xfer_done, setup_done, setup_rx, dis_done, usb_rst} <= '0;
    end else begin
      xfer_done <= (go && kind == 3'h0) ? 4'(1 << ep) : 4'h0;
      setup_done <= (go && kind == 3'h1) ? 4'(1 << ep) : 4'h0;
      setup_rx <= (go && kind == 3'h2) ? 4'(1 << ep) : 4'h0;
      dis_done <= (go && kind == 3'h4) ? 4'(1 << ep) : 4'h0;
      usb_rst <= go && kind == 3'h5;
    end
  end
endmodule // uepc_host_model

/* File: testbench/test_usb_device_in_endpoint_control.sv */
// Self-checking bench for the IN endpoint control block
`timescale 1ns/1ps
module test_usb_device_in_endpoint_control;
  import uepc_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wait_req;
  logic [1:0] resp;
  logic [7:0] in_f = 8'h00;
  logic [7:0] out_f = 8'h00;
  logic [3:0] fe = 4'h0;
  logic gin = 1'b0;
  logic gon = 1'b0;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [1:0] hep = 2'h0;
  logic [3:0] xd, sd, sr, dd, ena, dpl, fei, th;
  logic urst;
  logic irq;
  uepc_hs_e hs [4];
  int error_cnt = 0;
  int checks_done = 0;
  int pulses = 0;
  int m [8];
  int pv [3] = '{2, 1, 3};
  int nv [4] = '{2, 0, 1, 3};
  logic [31:0] seed = 32'h0000_c930;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] d = 32'h8048_8040;
  logic [1:0] rsp;
  uepc_in_endpoint_ctrl uepc_in_endpoint_ctrl_i (.ref_clk(ref_clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .avs_response(resp), .in_ep_flags_any(in_f), .out_ep_flags_any(out_f),
    .tx_fifo_empty_flag(fe), .xfer_done_evt(xd), .setup_done_evt(sd), .setup_rx_evt(sr),
    .pid_toggle_evt(4'h0), .disable_done_evt(dd), .usb_reset_evt(urst),
    .global_in_nak(gin), .global_out_nak(gon), .endpoint_enable_bit(ena),
    .disabled_irq_pulse(dpl), .in_handshake(hs), .tx_halt(th), .fifo_empty_irq(fei),
    .ep_irq(irq));
  uepc_host_model uepc_host_model_i (.ref_clk(ref_clk), .resetn(resetn), .go(go),
    .kind(kind), .ep(hep), .xfer_done(xd), .setup_done(sd), .setup_rx(sr),
    .dis_done(dd), .usb_rst(urst));
  // Clock and disabled-event counter for endpoint 1
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pulses <= pulses + int'(dpl[1]);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference control word after a software write
  function automatic int mdl(input int e, input int o, input logic [31:0] w);
    int r;
    r = o;
    r[31] = o[31] | w[31];
    r[30] = o[30] | (w[30] & o[31]);
    if (w[27]) r[17] = 1'b1;
    else if (w[26]) r[17] = 1'b0;
    if (e == 0) begin
      r[21] = o[21] | w[21];
      r[1:0] = w[1:0];
    end else begin
      if (w[29]) r[16] = 1'b1;
      else if (w[28]) r[16] = 1'b0;
      r[25:15] = {w[25:21], 1'b0, w[19:18], r[17], r[16], w[15]};
      r[10:0] = w[10:0];
    end
    return r;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge ref_clk);
    adr <= a;
    wdat <= v;
    rd_en <= !w;
    wr_en <= w;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        chk("bus wait", 32'h0, 32'h1);
        conclude();
      end
    end while (wait_req);
    // Answer taken at the edge that sees the wait lifted
    q = rdat;
    rsp = resp;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input int e, input logic [31:0] v);
    bus(1'b1, 4'(3 + e), v);
    m[3 + e] = mdl(e, m[3 + e], v);
  endtask
  task automatic rc(input int a);
    bus(1'b0, 4'(a), 32'h0);
    chk($sformatf("reg %0d", a), m[a], q);
  endtask
  task automatic rall();
    m[0] = {8'h00, out_f, 8'h00, in_f};
    m[7] = {30'h0, gon, gin};
    for (int a = 0; a < 8; a++) rc(a);
  endtask
  task automatic ev(input logic [2:0] k, input logic [1:0] e);
    @(posedge ref_clk);
    go <= 1'b1;
    kind <= k;
    hep <= e;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    m = '{0, 0, 0, 32'h0000_8000, 0, 0, 0, 0};
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rall();
    repeat (6) begin
      @(posedge ref_clk);
      in_f <= 8'(rnd());
      out_f <= 8'(rnd());
      fe <= 4'(rnd());
      {gin, gon} <= 2'(rnd());
      r = rnd();
      bus(1'b1, 4'h1, r);
      m[1] = r & 32'h00ff_00ff;
      r = rnd() & 32'h0000_00ff;
      bus(1'b1, 4'h2, r);
      m[2] = r;
      rall();
      chk("ep_irq", 32'(|(m[0] & m[1])), irq);
      chk("fifo irq", fe & m[2][3:0], fei);
    end
    gin <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(0, 32'h000c_0000 | k);
      rc(3);
    end
    for (int k = 0; k < 4; k++) begin
      wr(1, (d & 32'hfff3_ffff) | (k << 18));
      rc(4);
    end
    for (int k = 0; k < 3; k++) begin
      wr(1, d | (pv[k] << 28));
      rc(4);
    end
    for (int k = 0; k < 4; k++) begin
      wr(1, d | (nv[k] << 26));
      rc(4);
      chk("hs1", m[4][17] ? UEPC_HS_NAK : UEPC_HS_DATA, hs[1]);
      chk("halt1", 32'(m[4][17]), th[1]);
    end
    wr(1, d | 32'h0820_0000);
    chk("hs1", UEPC_HS_STALL, hs[1]);
    chk("halt1", 32'h1, th[1]);
    wr(1, (d & 32'hfff3_ffff) | 32'h0004_0000);
    chk("hs1", UEPC_HS_ZLP, hs[1]);
    ev(3'h0, 2'h1);
    m[4] = m[4] & 32'h3fff_ffff | 32'h0002_0000;
    rc(4);
    chk("ena", 32'h0, ena[1]);
    wr(1, 32'h8000_0000);
    wr(1, 32'h4000_0000);
    rc(4);
    ev(3'h4, 2'h1);
    m[4] = m[4] & 32'h3fff_ffff;
    rc(4);
    chk("disabled events", 32'h1, pulses);
    wr(2, 32'h8000_0000);
    ev(3'h1, 2'h2);
    m[5][31] = 1'b0;
    chk("ena", 32'h0, ena[2]);
    gin <= 1'b1;
    wr(0, 32'h0020_0000);
    chk("hs0", UEPC_HS_STALL, hs[0]);
    ev(3'h2, 2'h0);
    m[3] = m[3] & 32'hffdf_ffff | 32'h0002_0000;
    rc(3);
    ev(3'h5, 2'h0);
    for (int e = 4; e < 7; e++) m[e][15] = 1'b0;
    bus(1'b1, 4'hb, 32'hffff_ffff);
    chk("write resp", 32'h2, rsp);
    bus(1'b0, 4'hb, 32'h0);
    chk("read resp", 32'h2, 32'(rsp));
    chk("read data", 32'h0, q);
    rall();
    conclude();
  end
endmodule // test_usb_device_in_endpoint_control
